// *** hdl/pio_regs.svh ***
// register indices, field positions, reset values and widths of the upper pin banks
// Functional notes
// - input pin: data bit reads sampled level, 0 low, 1 high
// - output pin: pin driven low for data 0, high for data 1
// - each data bit drives output pins and monitors input pins
// - after reset data bits follow their pin levels, not a constant
// - mid bank data bit n maps to pin 16 plus n
// - high bank bits 13..0 map to pins 32..45; bits 15..14 reserved, reset 0
// - enable bit turns the pin function on; enables reset to 0
// - enable 0: pin function off, pin high impedance
// - enable 1: pin follows its direction and data bits
// - direction 0 means input; directions reset to 0
// - direction 1 means output driven from data bit
`ifndef PIO_REGS_SVH
`define PIO_REGS_SVH

// register indices; byte address is four times the index
`define PIO_IDX_LVL_MID   32'h0000_4405
`define PIO_IDX_EN_HIGH   32'h0000_4406
`define PIO_IDX_DIR_HIGH  32'h0000_4407
`define PIO_IDX_LVL_HIGH  32'h0000_4408
`define PIO_IDX_LSB       2

// bank geometry
`define PIO_REG_W         16
`define PIO_MID_PINS      16
`define PIO_HIGH_PINS     14
`define PIO_MID_FIRST_PIN 16
`define PIO_HIGH_FIRST_PIN 32
`define PIO_RSVD_MSB      15
`define PIO_RSVD_LSB      14
`define PIO_RSVD_W        2
`define PIO_PIN_MSB       13

// reset values
`define PIO_EN_HIGH_RST   16'h0000
`define PIO_DIR_HIGH_RST  16'h0000
`define PIO_RSVD_RST      2'h0
`define PIO_RDATA_RST     32'h0000_0000
`define PIO_SYNC_RST      1'b0

// byte lanes of the 16-bit registers
`define PIO_LANE0_MSB     7
`define PIO_LANE1_LSB     8

`endif

// *** hdl/pio_pkg.sv ***
// types shared by the upper pin bank files
package pio_pkg;

  // register selected by an apb address
  typedef enum logic [2:0] {
    PIO_SEL_NONE     = 3'b000,
    PIO_SEL_LVL_MID  = 3'b001,
    PIO_SEL_EN_HIGH  = 3'b010,
    PIO_SEL_DIR_HIGH = 3'b011,
    PIO_SEL_LVL_HIGH = 3'b100
  } pio_sel_t;

endpackage

// *** hdl/pio_sync.sv ***
// two-flop synchroniser for a vector of pin levels
`include "pio_regs.svh"
module pio_sync #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] stable_d;

  // first stage only feeds the second
  always_comb begin
    meta_d   = async_in;
    stable_d = meta_q;
  end

  // both stages, cleared at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= {WIDTH{`PIO_SYNC_RST}};
      stable_q <= {WIDTH{`PIO_SYNC_RST}};
    end else begin
      meta_q   <= meta_d;
      stable_q <= stable_d;
    end
  end

  assign sync_out = stable_q;

endmodule

// *** hdl/pio_bank.sv ***
// one bank of data bits with pin drive and pin monitoring
module pio_bank #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // configuration
  input  wire logic [WIDTH-1:0] pin_function_enable_bit,
  input  wire logic [WIDTH-1:0] pin_direction_bit,
  // software write
  input  wire logic [WIDTH-1:0] wr_mask,
  input  wire logic [WIDTH-1:0] wr_data,
  // pins
  input  wire logic [WIDTH-1:0] pin_sync,
  output logic      [WIDTH-1:0] pin_level_bit,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe
);

  logic [WIDTH-1:0] data_q;
  logic [WIDTH-1:0] data_d;
  logic [WIDTH-1:0] drive;

  // driving pins keep software value, others follow the pin
  always_comb begin
    drive = pin_function_enable_bit & pin_direction_bit;
    for (int i = 0; i < WIDTH; i++) begin
      if (drive[i]) begin
        data_d[i] = wr_mask[i] ? wr_data[i] : data_q[i];
      end else begin
        data_d[i] = pin_sync[i];
      end
    end
  end

  // data bits; after reset they track the pins since all start as inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= '0;
    end else begin
      data_q <= data_d;
    end
  end

  // pin drive: high impedance unless enabled output
  assign pin_out       = data_q;
  assign pin_oe        = drive;
  assign pin_level_bit = data_q;

endmodule

// *** hdl/pio_top.sv ***
// apb register slave and pin logic for pin banks 16..31 and 32..45
`include "pio_regs.svh"
module pio_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // mid bank configuration from the lower register block
  input  wire logic [15:0] mid_pin_enable,
  input  wire logic [15:0] mid_pin_direction,
  // mid bank pins 16..31
  input  wire logic [15:0] mid_pin_in,
  output logic      [15:0] mid_pin_out,
  output logic      [15:0] mid_pin_oe,
  // high bank pins 32..45
  input  wire logic [13:0] high_pin_in,
  output logic      [13:0] high_pin_out,
  output logic      [13:0] high_pin_oe
);

  // address decode: word aligned, index is the byte address over four
  function automatic pio_pkg::pio_sel_t pio_decode(input logic [31:0] addr);
    logic [31:0]       idx;
    pio_pkg::pio_sel_t sel;
    idx = addr >> `PIO_IDX_LSB;
    sel = pio_pkg::PIO_SEL_NONE;
    // misaligned addresses hit nothing and answer with an error
    if (addr[`PIO_IDX_LSB-1:0] == '0) begin
      case (idx)
        `PIO_IDX_LVL_MID: begin
          sel = pio_pkg::PIO_SEL_LVL_MID;
        end
        `PIO_IDX_EN_HIGH: begin
          sel = pio_pkg::PIO_SEL_EN_HIGH;
        end
        `PIO_IDX_DIR_HIGH: begin
          sel = pio_pkg::PIO_SEL_DIR_HIGH;
        end
        `PIO_IDX_LVL_HIGH: begin
          sel = pio_pkg::PIO_SEL_LVL_HIGH;
        end
        default: begin
          sel = pio_pkg::PIO_SEL_NONE;
        end
      endcase
    end
    return sel;
  endfunction

  // merge write data into a register under a bit mask
  function automatic logic [15:0] pio_merge(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [15:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  // write strobe of one register: an access-phase write that hits it
  function automatic logic pio_wr_hit(input logic              go,
                                      input pio_pkg::pio_sel_t cur,
                                      input pio_pkg::pio_sel_t target);
    return go && (cur == target);
  endfunction

  // bus decode and write strobes
  pio_pkg::pio_sel_t sel;
  logic              setup;
  logic              access;
  logic              wr_go;
  logic              wr_lvl_mid;
  logic              wr_en_high;
  logic              wr_dir_high;
  logic              wr_lvl_high;
  logic [15:0]       lane_mask;
  logic [15:0]       wdata16;

  // data bank write masks, levels and synchronised pins
  logic [15:0]       mid_wr_mask;
  logic [13:0]       high_wr_mask;
  logic [15:0]       mid_level;
  logic [13:0]       high_level;
  logic [15:0]       mid_sync;
  logic [13:0]       high_sync;

  // high bank configuration and reserved data bits
  logic [15:0]       en_high_q;
  logic [15:0]       en_high_d;
  logic [15:0]       dir_high_q;
  logic [15:0]       dir_high_d;
  logic [1:0]        rsvd_lvl_q;
  logic [1:0]        rsvd_lvl_d;

  // bus answer
  logic [31:0]       prdata_q;
  logic [31:0]       prdata_d;
  logic              pslverr_q;
  logic              pslverr_d;
  logic [15:0]       rd_val;

  // bus phases and write lanes
  always_comb begin
    sel       = pio_decode(paddr);
    setup     = psel & ~penable;
    access    = psel & penable;
    wr_go     = access & pwrite & (sel != pio_pkg::PIO_SEL_NONE);
    lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wdata16   = pwdata[`PIO_REG_W-1:0];
  end

  // one write strobe per register
  always_comb begin
    wr_lvl_mid  = pio_wr_hit(wr_go, sel, pio_pkg::PIO_SEL_LVL_MID);
    wr_en_high  = pio_wr_hit(wr_go, sel, pio_pkg::PIO_SEL_EN_HIGH);
    wr_dir_high = pio_wr_hit(wr_go, sel, pio_pkg::PIO_SEL_DIR_HIGH);
    wr_lvl_high = pio_wr_hit(wr_go, sel, pio_pkg::PIO_SEL_LVL_HIGH);
  end

  // per-bank write masks for the data registers
  always_comb begin
    mid_wr_mask  = '0;
    high_wr_mask = '0;
    if (wr_lvl_mid) begin
      mid_wr_mask = lane_mask;
    end
    if (wr_lvl_high) begin
      high_wr_mask = lane_mask[`PIO_PIN_MSB:0];
    end
  end

  // read value of the addressed register
  always_comb begin
    case (sel)
      pio_pkg::PIO_SEL_LVL_MID: begin
        rd_val = mid_level;
      end
      pio_pkg::PIO_SEL_EN_HIGH: begin
        rd_val = en_high_q;
      end
      pio_pkg::PIO_SEL_DIR_HIGH: begin
        rd_val = dir_high_q;
      end
      pio_pkg::PIO_SEL_LVL_HIGH: begin
        rd_val = {rsvd_lvl_q, high_level};
      end
      default: begin
        rd_val = '0;
      end
    endcase
  end

  // next values of configuration and reserved data bits
  always_comb begin
    en_high_d  = en_high_q;
    dir_high_d = dir_high_q;
    rsvd_lvl_d = rsvd_lvl_q;
    if (wr_en_high) begin
      en_high_d = pio_merge(en_high_q, wdata16, lane_mask);
    end
    if (wr_dir_high) begin
      dir_high_d = pio_merge(dir_high_q, wdata16, lane_mask);
    end
    // reserved bits sit in the upper byte lane only
    if (wr_lvl_high && pstrb[1]) begin
      rsvd_lvl_d = wdata16[`PIO_RSVD_MSB:`PIO_RSVD_LSB];
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_high_q  <= `PIO_EN_HIGH_RST;
      dir_high_q <= `PIO_DIR_HIGH_RST;
      rsvd_lvl_q <= `PIO_RSVD_RST;
    end else begin
      en_high_q  <= en_high_d;
      dir_high_q <= dir_high_d;
      rsvd_lvl_q <= rsvd_lvl_d;
    end
  end

  // answer is captured in the setup cycle, shown in the access cycle
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (setup) begin
      prdata_d  = (!pwrite) ? {16'h0000, rd_val} : `PIO_RDATA_RST;
      pslverr_d = (sel == pio_pkg::PIO_SEL_NONE);
    end
  end

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= `PIO_RDATA_RST;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // zero-wait answer during the access phase
  assign pready  = access;
  assign prdata  = access ? prdata_q : `PIO_RDATA_RST;
  assign pslverr = access & pslverr_q;

  // pin level synchronisers
  pio_sync #(
    .WIDTH (`PIO_MID_PINS)
  ) u_sync_mid (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (mid_pin_in),
    .sync_out (mid_sync)
  );

  pio_sync #(
    .WIDTH (`PIO_HIGH_PINS)
  ) u_sync_high (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (high_pin_in),
    .sync_out (high_sync)
  );

  // mid bank, pins 16..31
  pio_bank #(
    .WIDTH (`PIO_MID_PINS)
  ) u_bank_mid (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .pin_function_enable_bit (mid_pin_enable),
    .pin_direction_bit       (mid_pin_direction),
    .wr_mask                 (mid_wr_mask),
    .wr_data                 (wdata16),
    .pin_sync                (mid_sync),
    .pin_level_bit           (mid_level),
    .pin_out                 (mid_pin_out),
    .pin_oe                  (mid_pin_oe)
  );

  // high bank, pins 32..45
  pio_bank #(
    .WIDTH (`PIO_HIGH_PINS)
  ) u_bank_high (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .pin_function_enable_bit (en_high_q[`PIO_PIN_MSB:0]),
    .pin_direction_bit       (dir_high_q[`PIO_PIN_MSB:0]),
    .wr_mask                 (high_wr_mask),
    .wr_data                 (wdata16[`PIO_PIN_MSB:0]),
    .pin_sync                (high_sync),
    .pin_level_bit           (high_level),
    .pin_out                 (high_pin_out),
    .pin_oe                  (high_pin_oe)
  );

endmodule

// *** test/pio_pins.sv ***
// pin pads of the upper banks with outside levels
module pio_pins #(
  parameter int W = 16
) (
  // device side
  input  wire logic [W-1:0] drv,
  input  wire logic [W-1:0] oe,
  // outside side
  input  wire logic [W-1:0] ext,
  output logic      [W-1:0] lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // driven pins show the device, others the outside
  assign lvl = (oe & drv) | (~oe & ext);
endmodule

// *** test/pio_top_assertions.sv ***
// concurrent checks on the upper pin bank ports
module pio_top_assertions (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic [31:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic [15:0] mid_pin_enable,
  input wire logic [15:0] mid_pin_direction,
  input wire logic [15:0] mid_pin_in,
  input wire logic [15:0] mid_pin_out,
  input wire logic [15:0] mid_pin_oe,
  input wire logic [13:0] high_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        acc;
  logic        hit;
  logic [2:0]  calm_q;
  logic [2:0]  calm_d;
  logic [15:0] pin_q;
  logic [15:0] oe_q;
  // access phase and address decode
  assign acc = psel & penable;
  assign hit = paddr inside {32'h0001_1014, 32'h0001_1018, 32'h0001_101c, 32'h0001_1020};
  // edges since mid pins or drive last moved
  always_comb begin
    calm_d = calm_q;
    if (mid_pin_in != pin_q || mid_pin_oe != oe_q) begin
      calm_d = 3'h0;
    end else if (calm_q != 3'h7) begin
      calm_d = calm_q + 3'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calm_q <= 3'h0;
      pin_q  <= 16'h0000;
      oe_q   <= 16'h0000;
    end else begin
      calm_q <= calm_d;
      pin_q  <= mid_pin_in;
      oe_q   <= mid_pin_oe;
    end
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_zero_wait: assert property (psel && !penable ##1 acc |-> pready)
    else $error("pready late");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_unmapped_err: assert property (acc |-> pslverr == !hit && (hit || prdata == 32'h0000_0000))
    else $error("error flag wrong");
  a_mid_oe: assert property (mid_pin_oe == (mid_pin_enable & mid_pin_direction))
    else $error("mid drive enable wrong");
  a_oe_reset: assert property ($rose(presetn) |-> high_pin_oe == 14'h0000)
    else $error("high drive after reset");
  a_oe_hold: assert property (!(acc && pwrite) |=> $stable(high_pin_oe))
    else $error("high drive moved unwritten");
  a_mid_write: assert property (acc && pwrite && paddr == 32'h0001_1014 && pstrb == 4'hf
    && mid_pin_oe == 16'hffff |=> mid_pin_out == $past(pwdata[15:0]))
    else $error("mid drive not written");
  a_mid_input: assert property (acc && !pwrite && paddr == 32'h0001_1014 && calm_q >= 3'h5
    |-> (prdata[15:0] & ~mid_pin_oe) == (mid_pin_in & ~mid_pin_oe))
    else $error("mid input level wrong");
endmodule

bind pio_top pio_top_assertions i_pio_top_assertions (.pclk, .presetn, .paddr, .psel,
  .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .mid_pin_enable,
  .mid_pin_direction, .mid_pin_in, .mid_pin_out, .mid_pin_oe, .high_pin_oe);

// *** test/pio_top_tb.sv ***
// self-checking bench for the upper pin banks
module pio_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A_MD = 32'h0001_1014;
  localparam logic [31:0] A_EN = 32'h0001_1018;
  localparam logic [31:0] A_DR = 32'h0001_101c;
  localparam logic [31:0] A_HD = 32'h0001_1020;
  typedef struct {
    logic [31:0] a;
    logic [15:0] w;
    logic [15:0] x;
    logic        e;
  } pio_row_t;
  logic        pclk;
  logic        presetn;
  logic [31:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] m_en;
  logic [15:0] m_dir;
  logic [15:0] m_pin;
  logic [15:0] m_out;
  logic [15:0] m_oe;
  logic [15:0] m_ext;
  logic [13:0] h_pin;
  logic [13:0] h_out;
  logic [13:0] h_oe;
  logic [13:0] h_ext;
  logic [31:0] rd;
  logic        er;
  int          n_fail;
  int          samples_checked;
  pio_row_t    rows[7] = '{
    '{A_EN, 16'hffff, 16'hffff, 1'b0},
    '{A_DR, 16'hc000, 16'hc000, 1'b0},
    '{A_EN, 16'h0000, 16'h0000, 1'b0},
    '{A_DR, 16'h0000, 16'h0000, 1'b0},
    '{A_HD, 16'hc000, 16'hea5a, 1'b0},
    '{A_MD, 16'hffff, 16'h5a3c, 1'b0},
    '{32'h0001_1024, 16'h1234, 16'h0000, 1'b1}
  };
  // design and pin pads
  pio_top i_pio_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .mid_pin_enable(m_en), .mid_pin_direction(m_dir),
    .mid_pin_in(m_pin), .mid_pin_out(m_out), .mid_pin_oe(m_oe), .high_pin_in(h_pin),
    .high_pin_out(h_out), .high_pin_oe(h_oe));
  pio_pins #(.W(16)) i_pio_pins (.drv(m_out), .oe(m_oe), .ext(m_ext), .lvl(m_pin));
  pio_pins #(.W(14)) i_pio_pins_h (.drv(h_out), .oe(h_oe), .ext(h_ext), .lvl(h_pin));
  // clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // one apb transfer, then one idle edge
  task automatic apb(input logic [31:0] a, input logic w, input logic [15:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0000, d};
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    // answer taken at the rising edge that sees pready high
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    samples_checked++;
    if (s !== x) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #20us;
    n_fail++;
    complete_run();
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    {m_en, m_dir} = '0;
    m_ext = 16'h5a3c;
    h_ext = 14'h2a5a;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("h_oe", 32'h0, {18'h0, h_oe});
    apb(A_EN, 1'b0, 16'h0);
    chk("en", 32'h0, rd);
    apb(A_DR, 1'b0, 16'h0);
    chk("dir", 32'h0, rd);
    apb(A_HD, 1'b0, 16'h0);
    chk("hdat", {18'h0, h_ext}, rd);
    apb(A_MD, 1'b0, 16'h0);
    chk("mdat", {16'h0, m_ext}, rd);
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].w);
      apb(rows[i].a, 1'b0, 16'h0);
      chk("row", {16'h0, rows[i].x}, rd);
      chk("err", {31'h0, rows[i].e}, {31'h0, er});
    end
    pstrb <= 4'h1;
    apb(A_DR, 1'b1, 16'hffff);
    pstrb <= 4'hf;
    apb(A_DR, 1'b0, 16'h0);
    chk("lane", 32'h00ff, rd);
    apb(A_EN, 1'b1, 16'h3fff);
    apb(A_DR, 1'b1, 16'h3fff);
    apb(A_HD, 1'b1, 16'h1555);
    chk("h_pin", 32'h1555, {18'h0, h_pin});
    chk("h_oe", 32'h3fff, {18'h0, h_oe});
    apb(A_HD, 1'b0, 16'h0);
    chk("h_rd", 32'h1555, rd);
    apb(A_DR, 1'b1, 16'h0);
    h_ext <= 14'h0f0f;
    repeat (4) @(posedge pclk);
    apb(A_HD, 1'b0, 16'h0);
    chk("h_in", 32'h0f0f, rd);
    apb(A_DR, 1'b1, 16'h3fff);
    chk("h_drv", 32'h3fff, {18'h0, h_oe});
    apb(A_EN, 1'b1, 16'h0);
    chk("h_off", 32'h0, {18'h0, h_oe});
    chk("h_free", {18'h0, h_ext}, {18'h0, h_pin});
    m_en <= 16'hffff;
    m_dir <= 16'hffff;
    @(posedge pclk);
    apb(A_MD, 1'b1, 16'ha5c3);
    chk("m_pin", 32'ha5c3, {16'h0, m_pin});
    // reset in mid-run with the high bank driving
    apb(A_EN, 1'b1, 16'h3fff);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("h_oe_rst", 32'h0, {18'h0, h_oe});
    presetn <= 1'b1;
    @(posedge pclk);
    apb(A_EN, 1'b0, 16'h0);
    chk("en_rst", 32'h0, rd);
    apb(A_DR, 1'b0, 16'h0);
    chk("dir_rst", 32'h0, rd);
    complete_run();
  end
endmodule
